/* File: fir_router.sv */
// Fabric interrupt router top: gathers peripheral requests, gates and routes them.
// Assumes the fabric synchronises every routed output before use.
module fir_router
  import fir_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Register access
  input wire logic reg_sel,
  input wire logic reg_wr,
  input wire logic [4:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic reg_ack,
  // Direct peripheral requests
  input wire logic comms_block_irq,
  input wire logic software_irq,
  input wire logic main_pll_locked_irq,
  input wire logic main_pll_unlock_irq,
  input wire logic hp_dma_done_irq,
  input wire logic hp_dma_error_irq,
  input wire logic peripheral_dma_irq,
  input wire logic flash1_irq,
  input wire logic flash0_irq,
  input wire logic serial_port0_irq,
  input wire logic ddr_fabric_port_irq,
  input wire logic fabric_pll_unlock_irq,
  input wire logic fabric_pll_locked_irq,
  input wire logic ddr_io_cal_done_irq,
  // Memory error flags
  input wire logic sram0_ecc_irq,
  input wire logic sram1_ecc_irq,
  input wire logic can_ecc_irq,
  input wire logic ddr_ecc_irq,
  // Bridge events
  input wire logic bridge_error_irq,
  input wire logic bridge_disable_done_irq,
  input wire logic bridge_lock_timeout_irq,
  // Bus error responses
  input wire logic hp_dma_err_resp,
  input wire logic fabric_port0_err_resp,
  input wire logic fabric_port1_err_resp,
  input wire logic peripheral_dma_err_resp,
  input wire logic sys_ctrl_err_resp,
  // Fabric outputs
  output logic [15:0] fabric_irq_out,
  output logic comms_block_irq_out
);

  // ==========================================================================
  // Source decode
  function automatic logic pick(input logic [FIR_SPACE-1:0] vec, input fir_idx_type idx);
    pick = vec[idx];
  endfunction

  fir_cfg_if cfg ();

  // Composite sources are plain ORs of levels, so they stay high as long as
  // any contributor does; nothing here latches or clears a request.
  wire logic ecc_error_irq = sram0_ecc_irq | sram1_ecc_irq | can_ecc_irq | ddr_ecc_irq;
  wire logic ddr_bridge_irq = bridge_error_irq | bridge_disable_done_irq | bridge_lock_timeout_irq;
  wire logic bus_error_resp_irq = hp_dma_err_resp | fabric_port0_err_resp | fabric_port1_err_resp |
    peripheral_dma_err_resp | sys_ctrl_err_resp;

  logic [31:0] src_a;
  logic [31:0] src_b;
  always_comb begin
    src_a = FIR_ZERO_WORD;
    src_b = FIR_ZERO_WORD;
    src_a[FIR_A_COMMS] = comms_block_irq;
    src_a[FIR_A_SOFT] = software_irq;
    src_a[FIR_A_ECC] = ecc_error_irq;
    src_a[FIR_A_BRIDGE] = ddr_bridge_irq;
    src_a[FIR_A_BUSERR] = bus_error_resp_irq;
    src_a[FIR_A_MAIN_PLL_LOCK] = main_pll_locked_irq;
    src_a[FIR_A_HP_DMA_ERR] = hp_dma_error_irq;
    src_a[FIR_A_FLASH1] = flash1_irq;
    src_a[FIR_A_FLASH0] = flash0_irq;
    src_a[FIR_A_MAIN_PLL_LOST] = main_pll_unlock_irq;
    src_a[FIR_A_HP_DMA_DONE] = hp_dma_done_irq;
    src_a[FIR_A_PDMA] = peripheral_dma_irq;
    src_a[FIR_A_SPI0] = serial_port0_irq;
    src_b[FIR_B_DDR_PORT] = ddr_fabric_port_irq;
    src_b[FIR_B_FPLL_LOST] = fabric_pll_unlock_irq;
    src_b[FIR_B_FPLL_LOCK] = fabric_pll_locked_irq;
    src_b[FIR_B_IO_CAL] = ddr_io_cal_done_irq;
  end

  // ==========================================================================
  // Gating: each source has exactly one enable bit, wherever it is routed.
  wire logic [31:0] gated_a = src_a & cfg.enable_a;
  wire logic [31:0] gated_b = src_b & cfg.enable_b;
  wire logic [FIR_SPACE-1:0] gated = {1'b0, gated_b, gated_a};

  assign cfg.active_a = gated_a;
  assign cfg.active_b = gated_b;

  // ==========================================================================
  // Routing: purely combinational, so an output can glitch while the group
  // select or an enable changes; the fabric must synchronise and filter.
  genvar line;
  generate
    for (line = 0; line < FIR_LINES; line++) begin : g_line
      wire logic ded_term = pick(gated, FIR_DED[line]);
      wire logic grp_term = cfg.group1 ? pick(gated, FIR_GRP1[line]) : pick(gated, FIR_GRP0[line]);
      assign fabric_irq_out[line] = ded_term | grp_term;
    end
  endgenerate
  // Line tables are held in the package.

  // The comms block line is passed through unmasked as its own output.
  assign comms_block_irq_out = comms_block_irq;

  // ==========================================================================
  // Registers
  fir_regfile i_fir_regfile (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .reg_sel(reg_sel),
    .reg_wr(reg_wr),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .reg_ack(reg_ack),
    .cfg(cfg.regs)
  );

endmodule

/* File: fir_pkg.sv */
// Constants, register map and routing tables of the fabric interrupt router.
// Assumes a single bus clock; nothing here holds state.
package fir_pkg;

  // ==========================================================================
  // Register map
  localparam logic [4:0] FIR_OFS_ENABLE_A = 5'h00;
  localparam logic [4:0] FIR_OFS_ENABLE_B = 5'h04;
  localparam logic [4:0] FIR_OFS_ACTIVE_A = 5'h08;
  localparam logic [4:0] FIR_OFS_ACTIVE_B = 5'h0C;
  localparam logic [4:0] FIR_OFS_GROUP_SEL = 5'h10;
  localparam logic [31:0] FIR_RST_ENABLE = 32'h0000_0000;
  localparam logic FIR_RST_GROUP = 1'b0;
  localparam logic [31:0] FIR_ZERO_WORD = 32'h0000_0000;
  localparam int FIR_GROUP_BIT = 0;

  // ==========================================================================
  // Enable and reason bit positions
  localparam int FIR_A_COMMS = 29;
  localparam int FIR_A_SOFT = 28;
  localparam int FIR_A_ECC = 26;
  localparam int FIR_A_BRIDGE = 25;
  localparam int FIR_A_BUSERR = 24;
  localparam int FIR_A_MAIN_PLL_LOCK = 23;
  localparam int FIR_A_HP_DMA_ERR = 22;
  localparam int FIR_A_FLASH1 = 17;
  localparam int FIR_A_FLASH0 = 16;
  localparam int FIR_A_MAIN_PLL_LOST = 15;
  localparam int FIR_A_HP_DMA_DONE = 9;
  localparam int FIR_A_PDMA = 8;
  localparam int FIR_A_SPI0 = 0;
  localparam int FIR_B_DDR_PORT = 7;
  localparam int FIR_B_FPLL_LOST = 6;
  localparam int FIR_B_FPLL_LOCK = 5;
  localparam int FIR_B_IO_CAL = 3;
  localparam logic [31:0] FIR_MASK_A = 32'h37C3_8301;
  localparam logic [31:0] FIR_MASK_B = 32'h0000_00E8;

  // ==========================================================================
  // Routing: gated sources form one 65-bit space, first register at 0..31,
  // second at 32..63, and bit 64 is a constant zero for empty table cells.
  localparam int FIR_LINES = 16;
  localparam int FIR_SPACE = 65;
  typedef logic [6:0] fir_idx_type;
  localparam fir_idx_type FIR_B_BASE = 7'h20;
  localparam fir_idx_type FIR_NONE = 7'h40;
  localparam fir_idx_type FIR_I_COMMS = 7'h1D;
  localparam fir_idx_type FIR_I_SOFT = 7'h1C;
  localparam fir_idx_type FIR_I_ECC = 7'h1A;
  localparam fir_idx_type FIR_I_BRIDGE = 7'h19;
  localparam fir_idx_type FIR_I_BUSERR = 7'h18;
  localparam fir_idx_type FIR_I_MAIN_PLL_LOCK = 7'h17;
  localparam fir_idx_type FIR_I_HP_DMA_ERR = 7'h16;
  localparam fir_idx_type FIR_I_FLASH1 = 7'h11;
  localparam fir_idx_type FIR_I_FLASH0 = 7'h10;
  localparam fir_idx_type FIR_I_MAIN_PLL_LOST = 7'h0F;
  localparam fir_idx_type FIR_I_HP_DMA_DONE = 7'h09;
  localparam fir_idx_type FIR_I_PDMA = 7'h08;
  localparam fir_idx_type FIR_I_SPI0 = 7'h00;
  localparam fir_idx_type FIR_I_DDR_PORT = 7'h27;
  localparam fir_idx_type FIR_I_FPLL_LOST = 7'h26;
  localparam fir_idx_type FIR_I_FPLL_LOCK = 7'h25;
  localparam fir_idx_type FIR_I_IO_CAL = 7'h23;

  localparam fir_idx_type FIR_DED [0:15] = '{
    FIR_I_SPI0, FIR_NONE, FIR_NONE, FIR_NONE, FIR_NONE, FIR_NONE, FIR_NONE, FIR_NONE,
    FIR_I_PDMA, FIR_I_HP_DMA_DONE, FIR_NONE, FIR_NONE, FIR_NONE, FIR_NONE, FIR_NONE, FIR_I_MAIN_PLL_LOST};
  localparam fir_idx_type FIR_GRP0 [0:15] = '{
    FIR_I_FLASH0, FIR_I_FLASH1, FIR_NONE, FIR_NONE, FIR_NONE, FIR_NONE, FIR_NONE, FIR_NONE,
    FIR_I_HP_DMA_ERR, FIR_I_MAIN_PLL_LOCK, FIR_I_BUSERR, FIR_I_BRIDGE, FIR_I_ECC, FIR_NONE, FIR_I_SOFT,
    FIR_I_COMMS};
  localparam fir_idx_type FIR_GRP1 [0:15] = '{
    FIR_I_HP_DMA_ERR, FIR_I_MAIN_PLL_LOCK, FIR_I_BUSERR, FIR_I_BRIDGE, FIR_I_ECC, FIR_NONE, FIR_I_SOFT,
    FIR_I_COMMS, FIR_NONE, FIR_NONE, FIR_NONE, FIR_I_IO_CAL, FIR_NONE, FIR_I_FPLL_LOCK,
    FIR_I_FPLL_LOST, FIR_I_DDR_PORT};

endpackage

/* File: fir_cfg_if.sv */
// Carrier between the register file and the routing logic of the router.
// Assumes both ends sit in the same clock domain.
interface fir_cfg_if;
  import fir_pkg::*;
  logic [31:0] enable_a;
  logic [31:0] enable_b;
  logic group1;
  logic [31:0] active_a;
  logic [31:0] active_b;
  modport regs (output enable_a, output enable_b, output group1, input active_a, input active_b);
  modport route (input enable_a, input enable_b, input group1, output active_a, output active_b);
endinterface

/* File: fir_regfile.sv */
// Register file of the fabric interrupt router: enables, group select, reasons.
// Assumes a simple select/write strobe port, synchronous to clk.
module fir_regfile
  import fir_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Register access
  input wire logic reg_sel,
  input wire logic reg_wr,
  input wire logic [4:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic reg_ack,
  // Configuration toward the routing logic
  fir_cfg_if.regs cfg
);

  // ==========================================================================
  // Decode
  logic [31:0] enable_a_ff;
  logic [31:0] enable_b_ff;
  logic group1_ff;
  logic [31:0] rdata_ff;
  logic ack_ff;
  wire logic access = reg_sel & ce;
  wire logic wr_en_a = access & reg_wr & (reg_addr == FIR_OFS_ENABLE_A);
  wire logic wr_en_b = access & reg_wr & (reg_addr == FIR_OFS_ENABLE_B);
  wire logic wr_group = access & reg_wr & (reg_addr == FIR_OFS_GROUP_SEL);
  wire logic [31:0] nxt_enable_a = reg_wdata & FIR_MASK_A;
  wire logic [31:0] nxt_enable_b = reg_wdata & FIR_MASK_B;
  wire logic [31:0] group_word = {31'h0000_0000, group1_ff};
  // Reason words are sampled live; writes to them fall through the decode.
  wire logic [31:0] nxt_rdata =
    (reg_addr == FIR_OFS_ENABLE_A) ? enable_a_ff :
    (reg_addr == FIR_OFS_ENABLE_B) ? enable_b_ff :
    (reg_addr == FIR_OFS_ACTIVE_A) ? cfg.active_a :
    (reg_addr == FIR_OFS_ACTIVE_B) ? cfg.active_b :
    (reg_addr == FIR_OFS_GROUP_SEL) ? group_word : FIR_ZERO_WORD;

  // ==========================================================================
  // Storage
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      enable_a_ff <= FIR_RST_ENABLE;
      enable_b_ff <= FIR_RST_ENABLE;
      group1_ff <= FIR_RST_GROUP;
      rdata_ff <= FIR_ZERO_WORD;
      ack_ff <= 1'b0;
    end else if (ce) begin
      if (wr_en_a) begin
        enable_a_ff <= nxt_enable_a;
      end
      if (wr_en_b) begin
        enable_b_ff <= nxt_enable_b;
      end
      if (wr_group) begin
        group1_ff <= reg_wdata[FIR_GROUP_BIT];
      end
      if (reg_sel && !reg_wr) begin
        rdata_ff <= nxt_rdata;
      end
      ack_ff <= reg_sel;
    end
  end

  assign cfg.enable_a = enable_a_ff;
  assign cfg.enable_b = enable_b_ff;
  assign cfg.group1 = group1_ff;
  assign reg_rdata = rdata_ff;
  assign reg_ack = ack_ff;

endmodule

/* File: fir_router_monitor.sv */
// Checker for the fabric interrupt router, watching its top ports only.
// Assumes one bus clock and a synchronous active-low reset.
module fir_router_monitor
  import fir_pkg::*;
(
  // Clock, reset, register access
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic reg_sel,
  input wire logic reg_wr,
  input wire logic [4:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  // Requests and routed lines
  input wire logic comms_block_irq,
  input wire logic software_irq,
  input wire logic main_pll_locked_irq,
  input wire logic hp_dma_done_irq,
  input wire logic fabric_pll_locked_irq,
  input wire logic bridge_error_irq,
  input wire logic bridge_disable_done_irq,
  input wire logic bridge_lock_timeout_irq,
  input wire logic [15:0] fabric_irq_out,
  input wire logic comms_block_irq_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ======
  // Access steps
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_rd(logic [4:0] a);
    reg_sel && ce && !reg_wr && reg_addr == a;
  endsequence
  sequence s_wr(logic [4:0] a);
    reg_sel && ce && reg_wr && reg_addr == a;
  endsequence
  // ======
  // Checks; the path has no flop, so a line and its cause are seen at the same edge.
  a_reset_clears_lines: assert property ($rose(rst_n) |-> fabric_irq_out == 16'h0000)
    else $error("lines not clear after reset");
  a_line5_silent: assert property (fabric_irq_out[5] == 1'b0)
    else $error("line 5 raised");
  a_line13_cause: assert property (fabric_irq_out[13] |-> fabric_pll_locked_irq)
    else $error("line 13 without its source");
  a_line7_cause: assert property (fabric_irq_out[7] |-> comms_block_irq)
    else $error("line 7 without its source");
  a_line6_cause: assert property (fabric_irq_out[6] |-> software_irq)
    else $error("line 6 without its source");
  a_line9_cause: assert property (fabric_irq_out[9] |-> hp_dma_done_irq || main_pll_locked_irq)
    else $error("line 9 without a source");
  a_line3_bridge: assert property (fabric_irq_out[3] |-> bridge_error_irq || bridge_disable_done_irq ||
    bridge_lock_timeout_irq)
    else $error("line 3 without a bridge event");
  a_comms_copy: assert property (comms_block_irq_out == comms_block_irq)
    else $error("comms output differs from its request");
  a_group_readback: assert property (s_wr(5'h10) ##1 s_rd(5'h10) |=>
    reg_rdata == {31'h0, $past(reg_wdata[0], 2)})
    else $error("group select read back wrong");
  a_enable_a_bits: assert property (s_rd(5'h00) |=> (reg_rdata & ~32'h37C3_8301) == 32'h0)
    else $error("reserved enable bit reads one");
endmodule
bind fir_router fir_router_monitor i_fir_router_monitor (.*);

/* File: fir_fabric_sync.sv */
// Model of the fabric logic that takes in the routed interrupt lines.
// Assumes the bench clock; a real fabric may run a clock of its own.
module fir_fabric_sync
  import fir_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Routed lines in, synchronised lines out
  input wire logic [15:0] lines,
  output logic [15:0] lines_sync
);
  timeunit 1ns;
  timeprecision 1ps;
  // ======
  // Two stages, because the lines arrive with no clock stage of their own.
  logic [15:0] meta_ff;
  logic [15:0] sync_ff;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_ff <= 16'h0000;
      sync_ff <= 16'h0000;
    end else begin
      meta_ff <= lines;
      sync_ff <= meta_ff;
    end
  end
  // A shared line is only a hint; the source is confirmed from the reason registers.
  assign lines_sync = sync_ff;
endmodule

/* File: fir_router_tb_top.sv */
// Self-checking bench for the fabric interrupt router.
// Assumes each accepted register access is acknowledged one cycle later.
module fir_router_tb_top
  import fir_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic reg_sel = 1'b0;
  logic reg_wr = 1'b0;
  logic [4:0] reg_addr = 5'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic [25:0] src = 26'h3FF_FFFF;
  logic [31:0] reg_rdata, en_a, en_b;
  logic reg_ack, comms_block_irq_out, grp;
  logic [15:0] fabric_irq_out, lines_sync, exp_l;
  int seed = 6969;
  int errors = 0;
  int n_tests = 0;
  always #5 clk = ~clk;
  fir_router i_fir_router (
    .clk, .rst_n, .ce, .reg_sel, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata, .reg_ack,
    .comms_block_irq(src[0]), .software_irq(src[1]), .main_pll_locked_irq(src[2]), .main_pll_unlock_irq(src[3]),
    .hp_dma_done_irq(src[4]), .hp_dma_error_irq(src[5]), .peripheral_dma_irq(src[6]), .flash1_irq(src[7]),
    .flash0_irq(src[8]), .serial_port0_irq(src[9]), .ddr_fabric_port_irq(src[10]),
    .fabric_pll_unlock_irq(src[11]), .fabric_pll_locked_irq(src[12]), .ddr_io_cal_done_irq(src[13]),
    .sram0_ecc_irq(src[14]), .sram1_ecc_irq(src[15]), .can_ecc_irq(src[16]), .ddr_ecc_irq(src[17]),
    .bridge_error_irq(src[18]), .bridge_disable_done_irq(src[19]), .bridge_lock_timeout_irq(src[20]),
    .hp_dma_err_resp(src[21]), .fabric_port0_err_resp(src[22]), .fabric_port1_err_resp(src[23]),
    .peripheral_dma_err_resp(src[24]), .sys_ctrl_err_resp(src[25]), .fabric_irq_out, .comms_block_irq_out);
  fir_fabric_sync i_fir_fabric_sync (.clk, .rst_n, .lines(fabric_irq_out), .lines_sync);
  // ======
  // Expected values
  function automatic logic [31:0] raw_a(input logic [25:0] v);
    return {2'h0, v[0], v[1], 1'b0, |v[17:14], |v[20:18], |v[25:21], v[2], v[5], 4'h0, v[7], v[8], v[3],
      5'h0, v[4], v[6], 7'h0, v[9]};
  endfunction
  function automatic logic [31:0] raw_b(input logic [25:0] v);
    return {24'h0, v[10], v[11], v[12], 1'b0, v[13], 3'h0};
  endfunction
  function automatic logic [15:0] route_exp(input logic [31:0] a, input logic [31:0] b, input logic g);
    return {a[15] | (g ? b[7] : a[29]), g ? b[6] : a[28], g & b[5], !g & a[26], g ? b[3] : a[25], !g & a[24],
      a[9] | (!g & a[23]), a[8] | (!g & a[22]), g & a[29], g & a[28], 1'b0, g & a[26], g & a[25], g & a[24],
      g ? a[23] : a[17], a[0] | (g ? a[22] : a[16])};
  endfunction
  // ======
  // Checks and register access
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic acc(input logic w, input logic [4:0] a, input logic [31:0] d);
    reg_sel = 1'b1;
    reg_wr = w;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clk);
    #1 chk("ack", 32'h1, {31'h0, reg_ack});
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] exp, input string what);
    acc(1'b0, a, 32'h0);
    chk(what, exp, reg_rdata);
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // ======
  // Main sequence; sources stay high until the bench itself drops them.
  initial begin
    repeat (20) @(posedge clk);
    #1 rst_n = 1'b1;
    chk("lines_reset", 32'h0, {16'h0, fabric_irq_out});
    chk("ack_reset", 32'h0, {31'h0, reg_ack});
    chk("rdata_reset", 32'h0, reg_rdata);
    for (int i = 0; i < 6; i++) begin
      rd(5'(4 * i), 32'h0, "reg_reset");
    end
    ce = 1'b0;
    reg_wr = 1'b1;
    reg_addr = 5'h00;
    reg_wdata = 32'hFFFF_FFFF;
    @(posedge clk);
    #1 ce = 1'b1;
    rd(5'h00, 32'h0, "enable_frozen");
    acc(1'b1, 5'h00, 32'hFFFF_FFFF);
    acc(1'b1, 5'h04, 32'hFFFF_FFFF);
    acc(1'b1, 5'h08, 32'h0);
    acc(1'b1, 5'h0C, 32'h0);
    rd(5'h00, 32'h37C3_8301, "enable_a");
    rd(5'h04, 32'h0000_00E8, "enable_b");
    rd(5'h08, 32'h37C3_8301, "active_a");
    rd(5'h0C, 32'h0000_00E8, "active_b");
    acc(1'b1, 5'h10, 32'hFFFF_FFFF);
    rd(5'h10, 32'h1, "group_one");
    acc(1'b1, 5'h10, 32'hFFFF_FFFE);
    rd(5'h10, 32'h0, "group_zero");
    $display("test registers done");
    for (int i = 0; i < 252; i++) begin
      en_a = (i < 52) ? 32'hFFFF_FFFF : $random(seed);
      en_b = (i < 52) ? 32'hFFFF_FFFF : $random(seed);
      grp = (i < 52) ? (i >= 26) : 1'($random(seed));
      acc(1'b1, 5'h00, en_a);
      acc(1'b1, 5'h04, en_b);
      acc(1'b1, 5'h10, {31'($random(seed)), grp});
      src = (i < 52) ? 26'h1 << (i % 26) : 26'($random(seed));
      exp_l = route_exp(raw_a(src) & en_a, raw_b(src) & en_b, grp);
      rd(5'h08, raw_a(src) & en_a, "active_a");
      rd(5'h0C, raw_b(src) & en_b, "active_b");
      chk("lines", {16'h0, exp_l}, {16'h0, fabric_irq_out});
      chk("lines_sync", {16'h0, exp_l}, {16'h0, lines_sync});
      chk("comms_out", {31'h0, src[0]}, {31'h0, comms_block_irq_out});
    end
    $display("test routing done");
    final_report;
  end
endmodule
